// ==== cblsb_pkg.sv ====
// Purpose: Shared constants and types for the branch, load/store and bit-op execution unit
// Assumes: 8-bit data, 16-bit pointers and program counter
// Notes: Operation codes are decoded upstream; this unit executes one operation at a time
package cblsb_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam logic [15:0] ADDR_ZERO = 16'h0000;
	localparam logic [15:0] ADDR_ONE = 16'h0001;
	localparam logic [15:0] PC_STEP_ONE = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO = 16'h0002;
	localparam logic [15:0] PC_STEP_THREE = 16'h0003;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	// Status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_I = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam int MSB = 7;

	typedef enum logic [4:0] {
		CBLSB_OP_SKIP_IO_BIT_ZERO = 5'h00,
		CBLSB_OP_SKIP_IO_BIT_ONE = 5'h01,
		CBLSB_OP_BRANCH_FLAG_ONE = 5'h02,
		CBLSB_OP_BRANCH_FLAG_ZERO = 5'h03,
		CBLSB_OP_BRANCH_EQUAL = 5'h04,
		CBLSB_OP_BRANCH_UNEQUAL = 5'h05,
		CBLSB_OP_BRANCH_CARRY_ONE = 5'h06,
		CBLSB_OP_BRANCH_CARRY_ZERO = 5'h07,
		CBLSB_OP_BRANCH_SAME_HIGHER = 5'h08,
		CBLSB_OP_BRANCH_LOWER = 5'h09,
		CBLSB_OP_BRANCH_OVERFLOW_ZERO = 5'h0A,
		CBLSB_OP_BRANCH_IRQ_ON = 5'h0B,
		CBLSB_OP_BRANCH_IRQ_OFF = 5'h0C,
		CBLSB_OP_INDIRECT_READ = 5'h0D,
		CBLSB_OP_DISPLACED_READ = 5'h0E,
		CBLSB_OP_INDIRECT_WRITE = 5'h0F,
		CBLSB_OP_DISPLACED_WRITE = 5'h10,
		CBLSB_OP_DIRECT_READ = 5'h11,
		CBLSB_OP_DIRECT_WRITE = 5'h12,
		CBLSB_OP_PROGRAM_ROM_READ = 5'h13,
		CBLSB_OP_PUSH = 5'h14,
		CBLSB_OP_POP = 5'h15,
		CBLSB_OP_IO_BIT_SET = 5'h16,
		CBLSB_OP_IO_BIT_CLEAR = 5'h17,
		CBLSB_OP_ROTATE_LEFT_CARRY = 5'h18,
		CBLSB_OP_ROTATE_RIGHT_CARRY = 5'h19
	} cblsb_op_t;

	typedef enum logic [1:0] {
		CBLSB_PTR_FIRST = 2'h0,
		CBLSB_PTR_SECOND = 2'h1,
		CBLSB_PTR_THIRD = 2'h2
	} cblsb_ptr_t;

	typedef enum logic [1:0] {
		CBLSB_MODE_PLAIN = 2'h0,
		CBLSB_MODE_POST_INC = 2'h1,
		CBLSB_MODE_PRE_DEC = 2'h2
	} cblsb_mode_t;

	// Gray-coded along idle -> exec -> mem -> extra
	typedef enum logic [1:0] {
		CBLSB_ST_IDLE = 2'h0,
		CBLSB_ST_EXEC = 2'h1,
		CBLSB_ST_MEM = 2'h3,
		CBLSB_ST_EXTRA = 2'h2
	} cblsb_state_t;

	typedef struct packed {
		cblsb_op_t op;
		cblsb_ptr_t ptr;
		cblsb_mode_t mode;
		logic [2:0] bit_sel;
		logic [5:0] io_addr;
		logic [6:0] offset;
		logic [5:0] disp;
		logic [15:0] direct_addr;
		logic [7:0] reg_val;
		logic next_is_long;
	} cblsb_instr_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cblsb_mem_req_t;
endpackage : cblsb_pkg

// ==== cblsb_core.sv ====
// Purpose: Executes skips, flag branches, loads, stores, stack, I/O bit and rotate operations
// Assumes: One operation accepted when idle; memories answer read data on the cycle after rd
// Notes: Pointers, stack pointer, status flags and program counter are held here
`timescale 1ns/1ps
`default_nettype none
module cblsb_core (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire cblsb_pkg::cblsb_instr_t instr_in,
	input wire logic [7:0] data_rdata_in,
	input wire logic [7:0] io_rdata_in,
	input wire logic [7:0] rom_rdata_in,
	output logic ready_out,
	output logic done_out,
	output cblsb_pkg::cblsb_mem_req_t data_req_out,
	output cblsb_pkg::cblsb_mem_req_t io_req_out,
	output logic rom_rd_out,
	output logic [15:0] rom_addr_out,
	output logic [7:0] result_out,
	output logic result_valid_out,
	output logic [7:0] flags_out,
	output logic [15:0] pc_out,
	output logic [15:0] ptr_first_out,
	output logic [15:0] ptr_second_out,
	output logic [15:0] ptr_third_out,
	output logic [15:0] stack_ptr_out
);
	cblsb_pkg::cblsb_state_t state;
	cblsb_pkg::cblsb_instr_t cur;
	logic [15:0] ptr [3];
	logic [15:0] sp;
	logic [7:0] flags;
	logic [15:0] pc;
	logic [7:0] rot_val;
	logic rot_c;
	logic flag_sel;
	logic taken;
	logic [15:0] eff_addr;
	logic [15:0] cur_ptr;
	logic [15:0] branch_target;
	logic accept;

	assign accept = start_in && (state == cblsb_pkg::CBLSB_ST_IDLE);
	assign ready_out = (state == cblsb_pkg::CBLSB_ST_IDLE);
	assign cur_ptr = ptr[cur.ptr];

	// Sign-extended word offset, relative to the following instruction
	assign branch_target = pc + {{9{cur.offset[6]}}, cur.offset} + cblsb_pkg::PC_STEP_ONE;

	// Condition for every branch form
	always_comb begin
		flag_sel = flags[cur.bit_sel];
		case (cur.op)
			cblsb_pkg::CBLSB_OP_BRANCH_FLAG_ONE: taken = flag_sel;
			cblsb_pkg::CBLSB_OP_BRANCH_FLAG_ZERO: taken = !flag_sel;
			cblsb_pkg::CBLSB_OP_BRANCH_EQUAL: taken = flags[cblsb_pkg::FLAG_Z];
			cblsb_pkg::CBLSB_OP_BRANCH_UNEQUAL: taken = !flags[cblsb_pkg::FLAG_Z];
			cblsb_pkg::CBLSB_OP_BRANCH_CARRY_ONE,
			cblsb_pkg::CBLSB_OP_BRANCH_LOWER: taken = flags[cblsb_pkg::FLAG_C];
			cblsb_pkg::CBLSB_OP_BRANCH_CARRY_ZERO,
			cblsb_pkg::CBLSB_OP_BRANCH_SAME_HIGHER: taken = !flags[cblsb_pkg::FLAG_C];
			cblsb_pkg::CBLSB_OP_BRANCH_OVERFLOW_ZERO: taken = !flags[cblsb_pkg::FLAG_V];
			cblsb_pkg::CBLSB_OP_BRANCH_IRQ_ON: taken = flags[cblsb_pkg::FLAG_I];
			cblsb_pkg::CBLSB_OP_BRANCH_IRQ_OFF: taken = !flags[cblsb_pkg::FLAG_I];
			default: taken = 1'b0;
		endcase
	end

	// Effective data address; pre-decrement uses the lowered pointer
	always_comb begin
		case (cur.op)
			cblsb_pkg::CBLSB_OP_DISPLACED_READ,
			cblsb_pkg::CBLSB_OP_DISPLACED_WRITE: eff_addr = cur_ptr + {10'h000, cur.disp};
			cblsb_pkg::CBLSB_OP_DIRECT_READ,
			cblsb_pkg::CBLSB_OP_DIRECT_WRITE: eff_addr = cur.direct_addr;
			cblsb_pkg::CBLSB_OP_PUSH: eff_addr = sp;
			cblsb_pkg::CBLSB_OP_POP: eff_addr = sp + cblsb_pkg::ADDR_ONE;
			default: begin
				if (cur.mode == cblsb_pkg::CBLSB_MODE_PRE_DEC) begin
					eff_addr = cur_ptr - cblsb_pkg::ADDR_ONE;
				end else begin
					eff_addr = cur_ptr;
				end
			end
		endcase
	end

	// Rotate results through carry
	always_comb begin
		if (cur.op == cblsb_pkg::CBLSB_OP_ROTATE_LEFT_CARRY) begin
			rot_val = {cur.reg_val[6:0], flags[cblsb_pkg::FLAG_C]};
			rot_c = cur.reg_val[cblsb_pkg::MSB];
		end else begin
			rot_val = {flags[cblsb_pkg::FLAG_C], cur.reg_val[7:1]};
			rot_c = cur.reg_val[0];
		end
	end

	// Sequencer: idle, first execute cycle, memory cycle, extra cycle for ROM reads and long skips
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state <= cblsb_pkg::CBLSB_ST_IDLE;
			cur <= '0;
		end else begin
			case (state)
				cblsb_pkg::CBLSB_ST_IDLE: begin
					if (accept) begin
						cur <= instr_in;
						state <= cblsb_pkg::CBLSB_ST_EXEC;
					end
				end
				cblsb_pkg::CBLSB_ST_EXEC: begin
					if (cur.op == cblsb_pkg::CBLSB_OP_ROTATE_LEFT_CARRY ||
						cur.op == cblsb_pkg::CBLSB_OP_ROTATE_RIGHT_CARRY) begin
						state <= cblsb_pkg::CBLSB_ST_IDLE;
					end else if (cur.op inside {[cblsb_pkg::CBLSB_OP_BRANCH_FLAG_ONE :
						cblsb_pkg::CBLSB_OP_BRANCH_IRQ_OFF]}) begin
						state <= taken ? cblsb_pkg::CBLSB_ST_MEM : cblsb_pkg::CBLSB_ST_IDLE;
					end else if (cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO ||
						cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE) begin
						state <= cblsb_pkg::CBLSB_ST_MEM;
					end else begin
						state <= cblsb_pkg::CBLSB_ST_MEM;
					end
				end
				cblsb_pkg::CBLSB_ST_MEM: begin
					if (cur.op == cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ) begin
						state <= cblsb_pkg::CBLSB_ST_EXTRA;
					end else if ((cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO &&
						!io_rdata_in[cur.bit_sel]) ||
						(cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE &&
						io_rdata_in[cur.bit_sel])) begin
						// A skip over a long instruction needs the third cycle
						state <= cur.next_is_long ? cblsb_pkg::CBLSB_ST_EXTRA :
							cblsb_pkg::CBLSB_ST_IDLE;
					end else begin
						state <= cblsb_pkg::CBLSB_ST_IDLE;
					end
				end
				cblsb_pkg::CBLSB_ST_EXTRA: begin
					state <= cblsb_pkg::CBLSB_ST_IDLE;
				end
				default: state <= cblsb_pkg::CBLSB_ST_IDLE;
			endcase
		end
	end

	// Program counter
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pc <= cblsb_pkg::ADDR_ZERO;
		end else if (state == cblsb_pkg::CBLSB_ST_EXEC) begin
			if (taken) begin
				pc <= branch_target;
			end else if (cur.op != cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO &&
				cur.op != cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE) begin
				pc <= pc + cblsb_pkg::PC_STEP_ONE;
			end
		end else if (state == cblsb_pkg::CBLSB_ST_MEM &&
			(cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO ||
			cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE)) begin
			if ((cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO) != io_rdata_in[cur.bit_sel]) begin
				pc <= pc + (cur.next_is_long ? cblsb_pkg::PC_STEP_THREE :
					cblsb_pkg::PC_STEP_TWO);
			end else begin
				pc <= pc + cblsb_pkg::PC_STEP_ONE;
			end
		end
	end

	// Pointer pairs and stack pointer
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ptr[0] <= cblsb_pkg::ADDR_ZERO;
			ptr[1] <= cblsb_pkg::ADDR_ZERO;
			ptr[2] <= cblsb_pkg::ADDR_ZERO;
			sp <= cblsb_pkg::ADDR_ZERO;
		end else if (state == cblsb_pkg::CBLSB_ST_MEM) begin
			if (cur.op == cblsb_pkg::CBLSB_OP_INDIRECT_READ ||
				cur.op == cblsb_pkg::CBLSB_OP_INDIRECT_WRITE ||
				cur.op == cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ) begin
				if (cur.mode == cblsb_pkg::CBLSB_MODE_POST_INC) begin
					ptr[cur.ptr] <= cur_ptr + cblsb_pkg::ADDR_ONE;
				end else if (cur.mode == cblsb_pkg::CBLSB_MODE_PRE_DEC &&
					cur.op != cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ) begin
					ptr[cur.ptr] <= eff_addr;
				end
			end
			if (cur.op == cblsb_pkg::CBLSB_OP_PUSH) begin
				sp <= sp - cblsb_pkg::ADDR_ONE;
			end else if (cur.op == cblsb_pkg::CBLSB_OP_POP) begin
				sp <= sp + cblsb_pkg::ADDR_ONE;
			end
		end
	end

	// Status flags: only rotates touch them
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			flags <= cblsb_pkg::FLAGS_RESET;
		end else if (state == cblsb_pkg::CBLSB_ST_EXEC &&
			(cur.op == cblsb_pkg::CBLSB_OP_ROTATE_LEFT_CARRY ||
			cur.op == cblsb_pkg::CBLSB_OP_ROTATE_RIGHT_CARRY)) begin
			flags[cblsb_pkg::FLAG_C] <= rot_c;
			flags[cblsb_pkg::FLAG_Z] <= (rot_val == cblsb_pkg::DATA_ZERO);
			flags[cblsb_pkg::FLAG_N] <= rot_val[cblsb_pkg::MSB];
			flags[cblsb_pkg::FLAG_V] <= rot_val[cblsb_pkg::MSB] ^ rot_c;
			flags[cblsb_pkg::FLAG_S] <= rot_c;
		end
	end

	// Memory and I/O requests issued in the execute cycle; bit set/clear writes in the memory cycle
	always_comb begin
		data_req_out = '0;
		io_req_out = '0;
		rom_rd_out = 1'b0;
		rom_addr_out = ptr[cblsb_pkg::CBLSB_PTR_THIRD];
		if (state == cblsb_pkg::CBLSB_ST_EXEC) begin
			case (cur.op)
				cblsb_pkg::CBLSB_OP_INDIRECT_READ, cblsb_pkg::CBLSB_OP_DISPLACED_READ,
				cblsb_pkg::CBLSB_OP_DIRECT_READ, cblsb_pkg::CBLSB_OP_POP: begin
					data_req_out.rd = 1'b1;
					data_req_out.addr = eff_addr;
				end
				cblsb_pkg::CBLSB_OP_INDIRECT_WRITE, cblsb_pkg::CBLSB_OP_DISPLACED_WRITE,
				cblsb_pkg::CBLSB_OP_DIRECT_WRITE, cblsb_pkg::CBLSB_OP_PUSH: begin
					data_req_out.wr = 1'b1;
					data_req_out.addr = eff_addr;
					data_req_out.wdata = cur.reg_val;
				end
				cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ: rom_rd_out = 1'b1;
				cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO, cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE,
				cblsb_pkg::CBLSB_OP_IO_BIT_SET, cblsb_pkg::CBLSB_OP_IO_BIT_CLEAR: begin
					io_req_out.rd = 1'b1;
					io_req_out.addr = {10'h000, cur.io_addr};
				end
				default: begin
				end
			endcase
		end else if (state == cblsb_pkg::CBLSB_ST_MEM &&
			(cur.op == cblsb_pkg::CBLSB_OP_IO_BIT_SET ||
			cur.op == cblsb_pkg::CBLSB_OP_IO_BIT_CLEAR)) begin
			// Read-modify-write keeps the other bits of the location
			io_req_out.wr = 1'b1;
			io_req_out.addr = {10'h000, cur.io_addr};
			io_req_out.wdata = io_rdata_in;
			io_req_out.wdata[cur.bit_sel] = (cur.op == cblsb_pkg::CBLSB_OP_IO_BIT_SET);
		end
	end

	// Result register for reads and rotates
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			result_out <= cblsb_pkg::DATA_ZERO;
			result_valid_out <= 1'b0;
		end else begin
			result_valid_out <= 1'b0;
			if (state == cblsb_pkg::CBLSB_ST_EXEC && (cur.op == cblsb_pkg::CBLSB_OP_ROTATE_LEFT_CARRY ||
				cur.op == cblsb_pkg::CBLSB_OP_ROTATE_RIGHT_CARRY)) begin
				result_out <= rot_val;
				result_valid_out <= 1'b1;
			end else if (state == cblsb_pkg::CBLSB_ST_MEM && (cur.op == cblsb_pkg::CBLSB_OP_INDIRECT_READ ||
				cur.op == cblsb_pkg::CBLSB_OP_DISPLACED_READ || cur.op == cblsb_pkg::CBLSB_OP_DIRECT_READ ||
				cur.op == cblsb_pkg::CBLSB_OP_POP)) begin
				result_out <= data_rdata_in;
				result_valid_out <= 1'b1;
			end else if (state == cblsb_pkg::CBLSB_ST_EXTRA &&
				cur.op == cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ) begin
				result_out <= rom_rdata_in;
				result_valid_out <= 1'b1;
			end
		end
	end

	// Completion pulse marks the last cycle of each operation
	assign done_out = (state != cblsb_pkg::CBLSB_ST_IDLE) && (
		(state == cblsb_pkg::CBLSB_ST_EXTRA) ||
		(state == cblsb_pkg::CBLSB_ST_MEM && cur.op != cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ &&
			!(cur.next_is_long && (cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO ||
			cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE) &&
			((cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ZERO) != io_rdata_in[cur.bit_sel]))) ||
		(state == cblsb_pkg::CBLSB_ST_EXEC && (cur.op == cblsb_pkg::CBLSB_OP_ROTATE_LEFT_CARRY ||
			cur.op == cblsb_pkg::CBLSB_OP_ROTATE_RIGHT_CARRY ||
			(cur.op inside {[cblsb_pkg::CBLSB_OP_BRANCH_FLAG_ONE :
			cblsb_pkg::CBLSB_OP_BRANCH_IRQ_OFF]} && !taken))));

	assign flags_out = flags;
	assign pc_out = pc;
	assign ptr_first_out = ptr[0];
	assign ptr_second_out = ptr[1];
	assign ptr_third_out = ptr[2];
	assign stack_ptr_out = sp;

	// Checks
	property p_branch_time;
		@(posedge clk_in) disable iff (!rst_n_in)
		(state == cblsb_pkg::CBLSB_ST_EXEC && taken) |=> (state == cblsb_pkg::CBLSB_ST_MEM) ##1 ready_out;
	endproperty
	branch_taken_time_a: assert property (p_branch_time) else $error("taken branch not 2 cycles");
	branch_target_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == cblsb_pkg::CBLSB_ST_EXEC && taken) |=> pc == $past(branch_target))
		else $error("branch target wrong");
	equal_branch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == cblsb_pkg::CBLSB_ST_EXEC && cur.op == cblsb_pkg::CBLSB_OP_BRANCH_EQUAL)
		|=> (state == cblsb_pkg::CBLSB_ST_MEM) == $past(flags[cblsb_pkg::FLAG_Z]))
		else $error("equal branch condition");
	rom_read_time_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(accept && instr_in.op == cblsb_pkg::CBLSB_OP_PROGRAM_ROM_READ)
		|=> !done_out ##1 !done_out ##1 done_out ##1 result_valid_out) else $error("rom read not 3 cycles");
	load_time_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(accept && instr_in.op == cblsb_pkg::CBLSB_OP_DIRECT_READ)
		|=> data_req_out.rd ##1 done_out) else $error("direct read not 2 cycles");
	post_inc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == cblsb_pkg::CBLSB_ST_MEM && cur.op == cblsb_pkg::CBLSB_OP_INDIRECT_READ &&
		cur.mode == cblsb_pkg::CBLSB_MODE_POST_INC) |=> ptr[$past(cur.ptr)] == $past(cur_ptr) + 16'h0001)
		else $error("post increment missing");
	pre_dec_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(data_req_out.rd && cur.op == cblsb_pkg::CBLSB_OP_INDIRECT_READ &&
		cur.mode == cblsb_pkg::CBLSB_MODE_PRE_DEC) |-> data_req_out.addr == cur_ptr - 16'h0001)
		else $error("pre decrement address wrong");
	rotate_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == cblsb_pkg::CBLSB_ST_EXEC && cur.op == cblsb_pkg::CBLSB_OP_ROTATE_LEFT_CARRY)
		|=> flags[cblsb_pkg::FLAG_C] == $past(cur.reg_val[7]) && result_out[0] == $past(flags[0]))
		else $error("rotate left carry wrong");
	io_set_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(io_req_out.wr && cur.op == cblsb_pkg::CBLSB_OP_IO_BIT_SET)
		|-> io_req_out.wdata == (io_rdata_in | (8'h01 << cur.bit_sel))) else $error("io set wrong");
	push_flags_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == cblsb_pkg::CBLSB_ST_EXEC && cur.op == cblsb_pkg::CBLSB_OP_PUSH)
		|=> $stable(flags) ##1 $stable(flags)) else $error("push changed flags");
	cover_branch_c: cover property (@(posedge clk_in) state == cblsb_pkg::CBLSB_ST_EXEC && taken);
	cover_skip_long_c: cover property (@(posedge clk_in)
		state == cblsb_pkg::CBLSB_ST_EXTRA && cur.op == cblsb_pkg::CBLSB_OP_SKIP_IO_BIT_ONE);
	cover_rom_c: cover property (@(posedge clk_in) rom_rd_out);
endmodule : cblsb_core
`default_nettype wire

// ==== cblsb_mem_model.sv ====
// Purpose: Behavioural data memory, I/O space and program ROM for the execution unit
// Assumes: Read data is presented on the cycle after the read strobe
// Notes: Outside its valid window each read bus toggles, so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module cblsb_mem_model (
	input wire logic clk_in,
	input wire cblsb_pkg::cblsb_mem_req_t data_req_in,
	input wire cblsb_pkg::cblsb_mem_req_t io_req_in,
	input wire logic rom_rd_in,
	input wire logic [15:0] rom_addr_in,
	output logic [7:0] data_rdata_out,
	output logic [7:0] io_rdata_out,
	output logic [7:0] rom_rdata_out
);
	logic [7:0] dmem [256];
	logic [7:0] iomem [64];
	logic io_hold;
	logic rom_hold;
	initial begin
		for (int i = 0; i < 256; i++) begin
			dmem[i] = 8'(i * 3 + 1);
		end
		for (int i = 0; i < 64; i++) begin
			iomem[i] = 8'(i) ^ 8'hA5;
		end
		data_rdata_out = 8'h00;
		io_rdata_out = 8'h00;
		rom_rdata_out = 8'h00;
		io_hold = 1'b0;
		rom_hold = 1'b0;
	end
	// Only the low address byte is decoded, so pointer wrap aliases to the top byte
	always @(posedge clk_in) begin
		if (data_req_in.wr) dmem[data_req_in.addr[7:0]] <= data_req_in.wdata;
		data_rdata_out <= data_req_in.rd ? dmem[data_req_in.addr[7:0]] : ~data_rdata_out;
	end
	// Read byte held a second cycle for the read-modify-write of bit set and clear
	always @(posedge clk_in) begin
		if (io_req_in.wr) iomem[io_req_in.addr[5:0]] <= io_req_in.wdata;
		io_hold <= io_req_in.rd;
		if (io_req_in.rd) io_rdata_out <= iomem[io_req_in.addr[5:0]];
		else if (!io_hold) io_rdata_out <= ~io_rdata_out;
	end
	always @(posedge clk_in) begin
		rom_hold <= rom_rd_in;
		if (rom_rd_in) rom_rdata_out <= rom_addr_in[7:0] ^ 8'h3C;
		else if (!rom_hold) rom_rdata_out <= ~rom_rdata_out;
	end
endmodule : cblsb_mem_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the branch, load/store and bit-op unit
// Assumes: Memory model answers one cycle after each read strobe
// Notes: Branch passes rerun after each rotate so C, Z, N and V are each seen set and clear; I stays clear
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in, rst_n_in, start_in, ready, done, rom_rd, res_valid;
	cblsb_pkg::cblsb_instr_t instr_in;
	cblsb_pkg::cblsb_mem_req_t data_req, io_req;
	logic [7:0] d_rd, io_rd, rom_rd_data, result, flags;
	logic [15:0] rom_addr, pc, ptr_a, ptr_b, ptr_c, sp, exp_pc;
	logic [7:0] exp_flags;
	int error_cnt, checks;
	cblsb_core i_cblsb_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
		.instr_in(instr_in), .data_rdata_in(d_rd), .io_rdata_in(io_rd),
		.rom_rdata_in(rom_rd_data), .ready_out(ready), .done_out(done), .data_req_out(data_req),
		.io_req_out(io_req), .rom_rd_out(rom_rd), .rom_addr_out(rom_addr), .result_out(result),
		.result_valid_out(res_valid), .flags_out(flags), .pc_out(pc), .ptr_first_out(ptr_a),
		.ptr_second_out(ptr_b), .ptr_third_out(ptr_c), .stack_ptr_out(sp));
	cblsb_mem_model i_cblsb_mem_model (.clk_in(clk_in), .data_req_in(data_req),
		.io_req_in(io_req), .rom_rd_in(rom_rd), .rom_addr_in(rom_addr),
		.data_rdata_out(d_rd), .io_rdata_out(io_rd), .rom_rdata_out(rom_rd_data));
	task automatic final_report();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] dm(input logic [7:0] a);
		return i_cblsb_mem_model.dmem[a];
	endfunction : dm
	// Cycle count: done must rise exactly in the cycle the contract names
	task automatic run_op(input logic [4:0] op, input logic [1:0] p, input logic [1:0] m,
		input logic [2:0] b, input logic [15:0] a, input logic [6:0] off, input logic [7:0] rv,
		input logic lg, input int cyc);
		int n;
		@(negedge clk_in);
		instr_in.op = cblsb_pkg::cblsb_op_t'(op);
		instr_in.ptr = cblsb_pkg::cblsb_ptr_t'(p);
		instr_in.mode = cblsb_pkg::cblsb_mode_t'(m);
		instr_in.bit_sel = b;
		instr_in.io_addr = a[5:0];
		instr_in.direct_addr = a;
		instr_in.offset = off;
		instr_in.disp = off[5:0];
		instr_in.reg_val = rv;
		instr_in.next_is_long = lg;
		chk(ready, 1'b1);
		start_in = 1'b1;
		@(negedge clk_in);
		start_in = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 8) begin
			@(negedge clk_in);
			n++;
		end
		chk(16'(n), 16'(cyc));
		// Every operation other than a branch or skip steps the program counter once
		if (op >= 5'h0D) exp_pc = exp_pc + 16'h0001;
		@(negedge clk_in);
	endtask : run_op
	function automatic logic taken(input logic [4:0] op, input logic [2:0] b, input logic [7:0] f);
		case (op)
			5'h02: return f[b];
			5'h03: return !f[b];
			5'h04: return f[1];
			5'h05: return !f[1];
			5'h06, 5'h09: return f[0];
			5'h07, 5'h08: return !f[0];
			5'h0A: return !f[3];
			5'h0B: return f[7];
			default: return !f[7];
		endcase
	endfunction : taken
	task automatic br(input logic [4:0] op);
		logic [6:0] off;
		logic tk;
		off = op[0] ? 7'h40 : 7'h3F;
		tk = taken(op, op[2:0], exp_flags);
		run_op(op, 0, 0, op[2:0], 0, off, 0, 0, tk ? 2 : 1);
		exp_pc = exp_pc + 16'h0001 + (tk ? {{9{off[6]}}, off} : 16'h0000);
		chk(pc, exp_pc);
		chk(flags, exp_flags);
	endtask : br
	task automatic rot(input logic lf, input logic [7:0] rv);
		logic [7:0] r;
		logic c;
		r = lf ? {rv[6:0], exp_flags[0]} : {exp_flags[0], rv[7:1]};
		c = lf ? rv[7] : rv[0];
		run_op(lf ? 5'h18 : 5'h19, 0, 0, 0, 0, 0, rv, 0, 1);
		exp_flags[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
		chk(result, r);
		chk(flags, exp_flags);
		for (int i = 2; i <= 12; i++) br(5'(i));
	endtask : rot
	task automatic sk(input logic [4:0] op, input logic [2:0] b, input logic lg, input int cyc,
		input logic [15:0] st);
		run_op(op, 0, 0, b, 16'h0005, 0, 0, lg, cyc);
		exp_pc = exp_pc + st;
		chk(pc, exp_pc);
		chk(flags, exp_flags);
	endtask : sk
	task automatic ld(input logic [4:0] op, input logic [1:0] p, input logic [1:0] m,
		input logic [15:0] a, input logic [7:0] ea, input int cyc);
		logic [7:0] e;
		e = (op == 5'h13) ? ea ^ 8'h3C : dm(ea);
		run_op(op, p, m, 0, a, a[6:0], 0, 0, cyc);
		chk(result, e);
		chk(res_valid, 1'b1);
	endtask : ld
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Longest expected run is a few hundred cycles
	initial begin
		repeat (3000) @(posedge clk_in);
		error_cnt++;
		final_report();
	end
	initial begin
		{rst_n_in, start_in, error_cnt, checks, exp_pc, exp_flags} = '0;
		instr_in = '0;
		repeat (6) @(negedge clk_in);
		rst_n_in = 1'b1;
		chk(pc, 16'h0000);
		chk({flags, sp[7:0]}, 16'h0000);
		rot(1'b1, 8'h80);
		rot(1'b0, 8'h01);
		rot(1'b1, 8'h00);
		sk(5'h00, 3'h1, 1'b0, 2, 16'h0002);
		sk(5'h00, 3'h1, 1'b1, 3, 16'h0003);
		sk(5'h00, 3'h5, 1'b1, 2, 16'h0001);
		sk(5'h01, 3'h5, 1'b1, 3, 16'h0003);
		sk(5'h01, 3'h0, 1'b0, 2, 16'h0001);
		run_op(5'h16, 0, 0, 3'h0, 16'h0005, 0, 0, 0, 2);
		chk(i_cblsb_mem_model.iomem[5], 8'hA1);
		run_op(5'h17, 0, 0, 3'h7, 16'h0005, 0, 0, 0, 2);
		chk(i_cblsb_mem_model.iomem[5], 8'h21);
		ld(5'h0D, 0, 1, 0, 8'h00, 2);
		ld(5'h0D, 0, 1, 0, 8'h01, 2);
		chk(ptr_a, 16'h0002);
		ld(5'h0D, 0, 2, 0, 8'h01, 2);
		chk(ptr_a, 16'h0001);
		ld(5'h0E, 1, 0, 16'h003F, 8'h3F, 2);
		ld(5'h11, 0, 0, 16'h0042, 8'h42, 2);
		ld(5'h13, 2, 1, 0, 8'h00, 3);
		ld(5'h13, 2, 0, 0, 8'h01, 3);
		chk(ptr_c, 16'h0001);
		run_op(5'h0F, 2, 1, 0, 0, 0, 8'h5A, 0, 2);
		chk({dm(8'h01), ptr_c[7:0]}, 16'h5A02);
		run_op(5'h0F, 2, 2, 0, 0, 0, 8'hC3, 0, 2);
		chk({dm(8'h01), ptr_c[7:0]}, 16'hC301);
		run_op(5'h0F, 2, 0, 0, 0, 0, 8'h11, 0, 2);
		chk({dm(8'h01), ptr_c[7:0]}, 16'h1101);
		run_op(5'h10, 1, 0, 0, 0, 7'h02, 8'h77, 0, 2);
		chk({dm(8'h02), ptr_b[7:0]}, 16'h7700);
		run_op(5'h12, 0, 0, 0, 16'h0080, 0, 8'h99, 0, 2);
		chk(dm(8'h80), 8'h99);
		run_op(5'h14, 0, 0, 0, 0, 0, 8'h6D, 0, 2);
		run_op(5'h14, 0, 0, 0, 0, 0, 8'h2E, 0, 2);
		chk(sp, 16'hFFFE);
		ld(5'h15, 0, 0, 0, 8'hFF, 2);
		ld(5'h15, 0, 0, 0, 8'h00, 2);
		chk(sp, 16'h0000);
		chk(flags, exp_flags);
		chk(pc, exp_pc);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
